// ===== pkg/dpot_defs.vh
// constants shared by the dual pot serial control design
// assumes the including file runs on a 250 MHz mclk
// Function
// RULE1 - opcode, address and data bits sampled on rising serial clock
// RULE2 - read data put on serial output at falling serial clock
// RULE3 - link works in clock modes (0, 0) and (1, 1) only
// RULE4 - two address pins give a 2-bit address, four devices per bus
// RULE5 - transfer acted on only when its address matches the pins
// RULE6 - chip select high: output released, standby unless writing
// RULE7 - master drops chip select before each command sequence
// RULE8 - chip select rise after valid write starts non-volatile write
// RULE9 - write protect low blocks stored writes, wiper writes still allowed
// RULE10 - write protect falling during select aborts pending write
// RULE11 - non-volatile write once started always runs to completion
// RULE12 - master lowers pause only while serial clock is low
// RULE13 - paused: output released, input ignored, sequence state kept
// RULE14 - pause released while clock low, sequence then continues
// RULE15 - at power-up stored setting 0 loads each wiper register
// RULE16 - two 6-bit wiper registers each select one of 64 taps
// RULE17 - four 6-bit stored settings per wiper register
// RULE18 - wiper and stored settings written only over the serial link
// RULE19 - first byte after select loads 8-bit instruction, six opcodes
// RULE20 - exactly one tap connected per pot, chosen by wiper register
// RULE21 - commands move wiper to and from settings, plus step mode
// RULE22 - master samples output on rising edge after each falling edge
`ifndef DPOT_DEFS_VH
`define DPOT_DEFS_VH

// ----------------------------------------
// instruction byte fields
// ----------------------------------------
`define DPOT_F_OP_HI 7
`define DPOT_F_OP_LO 5
`define DPOT_F_POT 4
`define DPOT_F_IDX_HI 3
`define DPOT_F_IDX_LO 2
`define DPOT_F_ADR_HI 1
`define DPOT_F_ADR_LO 0

// ----------------------------------------
// opcodes
// ----------------------------------------
`define DPOT_OP_READ 3'h0
`define DPOT_OP_WR_WPR 3'h1
`define DPOT_OP_WR_SET 3'h2
`define DPOT_OP_STORE 3'h3
`define DPOT_OP_RECALL 3'h4
`define DPOT_OP_STEP 3'h5

// ----------------------------------------
// values and timing
// ----------------------------------------
`define DPOT_WPR_MAX 6'h3f
`define DPOT_WPR_MIN 6'h00
`define DPOT_SET_RST 6'h00
`define DPOT_PIN_RST 7'h1c
`define DPOT_CLK_MHZ 250
`define DPOT_NVW_NS 5000
`define DPOT_NVW_CYC ((`DPOT_NVW_NS * `DPOT_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/dpot_sync.v
// two-stage synchroniser for the serial pins
// assumes a synchronously released active-low reset
`timescale 1ns/1ns
`default_nettype none

module dpot_sync #(
    parameter WIDTH = 7,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    // first stage read by the second only
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/dpot_nvm.v
// eight stored wiper settings with a timed write cycle
// assumes write starts come as single-cycle pulses from the top
`timescale 1ns/1ns
`default_nettype none
`include "dpot_defs.vh"

module dpot_nvm #(
    parameter WR_CYC = `DPOT_NVW_CYC,
    parameter CW = 13
) (
    input wire clk,
    input wire rst_n,
    input wire wr_start,
    input wire [2:0] wr_addr,
    input wire [5:0] wr_data,
    output reg busy_q,
    output wire [47:0] set_flat
);

    localparam integer LAST_I = WR_CYC - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    reg [5:0] mem_q [0:7];
    reg [CW-1:0] cnt_q;
    reg [2:0] adr_q;
    reg [5:0] dat_q;
    integer i;

    // ----------------------------------------
    // write cycle
    // ----------------------------------------
    // starts while busy are dropped; protect pin not seen here
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                mem_q[i] <= `DPOT_SET_RST;
            end
            busy_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            adr_q <= 3'h0;
            dat_q <= 6'h00;
        end else if (wr_start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= LAST;
            adr_q <= wr_addr;
            dat_q <= wr_data;
        end else if (busy_q) begin
            if (cnt_q == {CW{1'b0}}) begin
                mem_q[adr_q] <= dat_q; // RULE11 RULE17
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_flat
            assign set_flat[6*g+5:6*g] = mem_q[g];
        end
    endgenerate

endmodule

`default_nettype wire

// ===== rtl/dpot_top.v
// serial control of two 64-tap pots with stored settings
// assumes the serial pins are asynchronous to mclk and sck is
// well below mclk/4 so each level lasts several mclk cycles
`timescale 1ns/1ns
`default_nettype none
`include "dpot_defs.vh"

module dpot_top #(
    parameter NVW_CYC = `DPOT_NVW_CYC
) (
    input wire mclk,
    input wire nrst,
    input wire sck,
    input wire cs_n,
    input wire si,
    input wire hold_n,
    input wire wp_n,
    input wire dev_addr_bit0,
    input wire dev_addr_bit1,
    output reg so_q,
    output reg so_oe_q,
    output reg [5:0] wiper_position_reg0_q,
    output reg [5:0] wiper_position_reg1_q,
    output reg [63:0] tap_sel0_q,
    output reg [63:0] tap_sel1_q,
    output reg nv_busy_q,
    output reg standby_q
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [5:0] get_set;
        input [47:0] f;
        input [2:0] a;
        reg [47:0] t;
        begin
            t = f >> (6 * a);
            get_set = t[5:0];
        end
    endfunction

    function [63:0] onehot;
        input [5:0] v;
        begin
            onehot = 64'h0000_0000_0000_0001 << v;
        end
    endfunction

    function [5:0] step;
        input [5:0] v;
        input up;
        begin
            if (up && v != `DPOT_WPR_MAX) begin
                step = v + 6'h01;
            end else if (!up && v != `DPOT_WPR_MIN) begin
                step = v - 6'h01;
            end else begin
                step = v;
            end
        end
    endfunction

    // ----------------------------------------
    // reset release and pin sampling
    // ----------------------------------------
    reg [1:0] rst_s_q;
    wire rst_n;
    wire [6:0] pin_s;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s_q <= 2'b00;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_n = rst_s_q[1];

    dpot_sync #(
        .WIDTH(7),
        .RST_VAL(`DPOT_PIN_RST)
    ) u_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din({dev_addr_bit1, dev_addr_bit0, wp_n, hold_n, cs_n, si, sck}),
        .dout(pin_s)
    );

    wire sck_s = pin_s[0];
    wire si_s = pin_s[1];
    wire cs_s = pin_s[2];
    wire hold_s = pin_s[3];
    wire wp_s = pin_s[4];
    wire [1:0] addr_s = pin_s[6:5];

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg sck_p_q, cs_p_q;
    reg paused_q, paused_d;
    reg started_q, started_d;
    reg [2:0] bit_q, bit_d;
    reg [1:0] byte_q, byte_d;
    reg [7:0] shr_q, shr_d;
    reg [7:0] instr_q, instr_d;
    reg sel_q, sel_d;
    reg ign_q, ign_d;
    reg pend_q, pend_d;
    reg [2:0] pend_adr_q, pend_adr_d;
    reg [5:0] pend_dat_q, pend_dat_d;
    reg abort_q, abort_d;
    reg [7:0] out_q, out_d;
    reg rec_q, rec_d;
    reg so_d, so_oe_d;
    reg [5:0] wpr0_d, wpr1_d;
    reg wen;
    reg wpot;
    reg [5:0] wval;
    reg nv_go;
    reg [7:0] nb;
    reg [5:0] cur;

    wire [47:0] set_flat;
    wire nv_busy;

    wire sck_rise = sck_s & ~sck_p_q;
    wire sck_fall = ~sck_s & sck_p_q;
    wire cs_fall = ~cs_s & cs_p_q;
    wire cs_rise = cs_s & ~cs_p_q;
    wire [2:0] op = instr_q[`DPOT_F_OP_HI:`DPOT_F_OP_LO];
    wire [2:0] sadr = instr_q[`DPOT_F_POT:`DPOT_F_IDX_LO];

    // ----------------------------------------
    // sequence decode
    // ----------------------------------------
    always @* begin
        started_d = started_q;
        bit_d = bit_q;
        byte_d = byte_q;
        shr_d = shr_q;
        instr_d = instr_q;
        sel_d = sel_q;
        ign_d = ign_q;
        pend_d = pend_q;
        pend_adr_d = pend_adr_q;
        pend_dat_d = pend_dat_q;
        abort_d = abort_q;
        out_d = out_q;
        rec_d = rec_q;
        so_d = so_q;
        wpr0_d = wiper_position_reg0_q;
        wpr1_d = wiper_position_reg1_q;
        wen = 1'b0;
        wpot = 1'b0;
        wval = 6'h00;
        nv_go = 1'b0;
        nb = {shr_q[6:0], si_s};
        cur = instr_q[`DPOT_F_POT] ? wiper_position_reg1_q :
            wiper_position_reg0_q;

        // pause only entered or left while sck is low, except deselect clears it at any sck level
        if (cs_s) begin
            paused_d = 1'b0;
        end else if (!paused_q && !hold_s && !sck_s) begin
            paused_d = 1'b1; // RULE12
        end else if (paused_q && hold_s && !sck_s) begin
            paused_d = 1'b0; // RULE14
        end else begin
            paused_d = paused_q;
        end

        if (cs_fall) begin
            started_d = 1'b1; // RULE7
            bit_d = 3'h0;
            byte_d = 2'h0;
            sel_d = 1'b0;
            ign_d = 1'b0;
            pend_d = 1'b0;
            abort_d = 1'b0;
        end else if (cs_s) begin
            started_d = 1'b0;
            // partial byte at the rise means no valid write
            if (cs_rise && pend_q && !abort_q && bit_q == 3'h0 &&
                wp_s && !nv_busy) begin
                nv_go = 1'b1; // RULE8
            end
            pend_d = 1'b0;
        end else if (started_q) begin
            if (!wp_s) begin
                abort_d = 1'b1; // RULE10
                pend_d = 1'b0;
            end
            // paused edges do nothing, state held
            if (sck_rise && !paused_q && !ign_q) begin // RULE13
                shr_d = nb; // RULE1
                bit_d = bit_q + 3'h1;
                if (byte_q == 2'h0) begin
                    if (bit_q == 3'h7) begin
                        instr_d = nb; // RULE19
                        byte_d = 2'h1;
                        if (nb[`DPOT_F_ADR_HI:`DPOT_F_ADR_LO] != addr_s ||
                            nb[`DPOT_F_OP_HI:`DPOT_F_OP_LO] >
                            `DPOT_OP_STEP) begin
                            ign_d = 1'b1; // RULE5 RULE4
                        end else begin
                            sel_d = 1'b1;
                            case (nb[`DPOT_F_OP_HI:`DPOT_F_OP_LO])
                                `DPOT_OP_RECALL: begin
                                    wen = 1'b1; // RULE21
                                    wpot = nb[`DPOT_F_POT];
                                    wval = get_set(set_flat,
                                        nb[`DPOT_F_POT:`DPOT_F_IDX_LO]);
                                end
                                `DPOT_OP_STORE: begin
                                    if (wp_s && !abort_q) begin
                                        pend_d = 1'b1; // RULE9 RULE21
                                        pend_adr_d =
                                            nb[`DPOT_F_POT:`DPOT_F_IDX_LO];
                                        pend_dat_d = nb[`DPOT_F_POT] ?
                                            wiper_position_reg1_q :
                                            wiper_position_reg0_q;
                                    end
                                end
                                `DPOT_OP_READ: begin
                                    out_d = {2'b00, nb[`DPOT_F_POT] ?
                                        wiper_position_reg1_q :
                                        wiper_position_reg0_q};
                                end
                                default: begin
                                    out_d = out_q;
                                end
                            endcase
                        end
                    end
                end else begin
                    if (op == `DPOT_OP_STEP) begin
                        wen = 1'b1; // RULE21
                        wpot = instr_q[`DPOT_F_POT];
                        wval = step(cur, si_s);
                    end
                    if (bit_q == 3'h7) begin
                        if (byte_q != 2'h3) begin
                            byte_d = byte_q + 2'h1;
                        end
                        if (byte_q == 2'h1) begin
                            case (op)
                                `DPOT_OP_WR_WPR: begin
                                    wen = 1'b1; // RULE18
                                    wpot = instr_q[`DPOT_F_POT];
                                    wval = nb[5:0];
                                end
                                `DPOT_OP_WR_SET: begin
                                    if (wp_s && !abort_q) begin
                                        pend_d = 1'b1; // RULE9 RULE18
                                        pend_adr_d = sadr;
                                        pend_dat_d = nb[5:0];
                                    end
                                end
                                `DPOT_OP_READ: begin
                                    out_d = {2'b00, get_set(set_flat, sadr)};
                                end
                                default: begin
                                    out_d = out_q;
                                end
                            endcase
                        end
                    end
                end
            end
            if (sck_fall && !paused_q && sel_q && op == `DPOT_OP_READ &&
                byte_q != 2'h0) begin
                so_d = out_q[7]; // RULE2 RULE3
                out_d = {out_q[6:0], 1'b0};
            end
        end

        if (wen && !wpot) begin
            wpr0_d = wval;
        end
        if (wen && wpot) begin
            wpr1_d = wval;
        end
        // one recall right after reset, stored contents are valid then
        if (!rec_q) begin
            rec_d = 1'b1;
            wpr0_d = get_set(set_flat, 3'h0); // RULE15
            wpr1_d = get_set(set_flat, 3'h4); // RULE15
        end

        so_oe_d = ~cs_s & ~paused_d & started_q & sel_q & // RULE6 RULE13
            (op == `DPOT_OP_READ) & (byte_q != 2'h0);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_p_q <= 1'b0;
            cs_p_q <= 1'b1;
            paused_q <= 1'b0;
            started_q <= 1'b0;
            bit_q <= 3'h0;
            byte_q <= 2'h0;
            shr_q <= 8'h00;
            instr_q <= 8'h00;
            sel_q <= 1'b0;
            ign_q <= 1'b0;
            pend_q <= 1'b0;
            pend_adr_q <= 3'h0;
            pend_dat_q <= 6'h00;
            abort_q <= 1'b0;
            out_q <= 8'h00;
            rec_q <= 1'b0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            wiper_position_reg0_q <= 6'h00;
            wiper_position_reg1_q <= 6'h00;
            tap_sel0_q <= 64'h0000_0000_0000_0001;
            tap_sel1_q <= 64'h0000_0000_0000_0001;
            nv_busy_q <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            sck_p_q <= sck_s;
            cs_p_q <= cs_s;
            paused_q <= paused_d;
            started_q <= started_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            shr_q <= shr_d;
            instr_q <= instr_d;
            sel_q <= sel_d;
            ign_q <= ign_d;
            pend_q <= pend_d;
            pend_adr_q <= pend_adr_d;
            pend_dat_q <= pend_dat_d;
            abort_q <= abort_d;
            out_q <= out_d;
            rec_q <= rec_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
            wiper_position_reg0_q <= wpr0_d; // RULE16
            wiper_position_reg1_q <= wpr1_d; // RULE16
            tap_sel0_q <= onehot(wiper_position_reg0_q); // RULE20
            tap_sel1_q <= onehot(wiper_position_reg1_q); // RULE20
            nv_busy_q <= nv_busy | nv_go;
            standby_q <= cs_s & ~nv_busy & ~nv_go; // RULE6
        end
    end

    // ----------------------------------------
    // stored settings
    // ----------------------------------------
    dpot_nvm #(
        .WR_CYC(NVW_CYC),
        .CW(13)
    ) u_nvm (
        .clk(mclk),
        .rst_n(rst_n),
        .wr_start(nv_go),
        .wr_addr(pend_adr_q),
        .wr_data(pend_dat_q),
        .busy_q(nv_busy),
        .set_flat(set_flat)
    );

endmodule

`default_nettype wire

// ===== sim/dpot_checker.sv
// assertion checker for the dual pot serial control top
// assumes a short write time and sck levels of at least 6 mclk
`timescale 1ns/1ns
`default_nettype none

module dpot_checker #(
    parameter int NVW_CYC = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic dev_addr_bit0,
    input wire logic dev_addr_bit1,
    input wire logic so_q,
    input wire logic so_oe_q,
    input wire logic [5:0] wiper_position_reg0_q,
    input wire logic [5:0] wiper_position_reg1_q,
    input wire logic [63:0] tap_sel0_q,
    input wire logic [63:0] tap_sel1_q,
    input wire logic nv_busy_q,
    input wire logic standby_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // ------------------------------------------------
    // helper logic
    // ------------------------------------------------
    // counts busy cycles, since a repetition cannot take a parameter
    logic [15:0] busy_cnt_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= nv_busy_q ? busy_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    sequence s_idle;
        (cs_n && !nv_busy_q) [*8];
    endsequence
    sequence s_paused;
        (!hold_n && !sck && !cs_n) [*6];
    endsequence

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_idle_standby: assert property (s_idle |-> standby_q)
        else $error("no standby while deselected and idle");
    a_busy_standby: assert property (nv_busy_q [*2] |-> !standby_q)
        else $error("standby during stored write");
    a_deselect_quiet: assert property (cs_n [*6] |-> !so_oe_q)
        else $error("output driven while deselected");
    a_paused_release: assert property (s_paused |-> !so_oe_q)
        else $error("output driven while paused");
    a_so_fall: assert property (
        $changed(so_q) && so_oe_q && $past(so_oe_q) |-> !sck && $past(sck, 5))
        else $error("output bit moved off a falling clock");
    a_tap_onehot: assert property (
        tap_sel0_q == (64'h1 << $past(wiper_position_reg0_q)) &&
        tap_sel1_q == (64'h1 << $past(wiper_position_reg1_q)))
        else $error("tap select not one-hot of wiper");
    a_wiper_serial: assert property (cs_n [*8] |=>
        $stable(wiper_position_reg0_q) && $stable(wiper_position_reg1_q))
        else $error("wiper moved without a frame");
    a_busy_start: assert property (
        $rose(nv_busy_q) |-> cs_n && $past(cs_n, 2))
        else $error("stored write began without select rise");
    a_wp_block: assert property (
        $rose(nv_busy_q) |-> $past(wp_n, 6))
        else $error("stored write began under write protect");
    a_busy_len: assert property (
        $fell(nv_busy_q) |-> busy_cnt_q == NVW_CYC + 1)
        else $error("stored write length wrong");
endmodule

bind dpot_top dpot_checker #(.NVW_CYC(NVW_CYC)) i_chk (
    .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .dev_addr_bit0(dev_addr_bit0),
    .dev_addr_bit1(dev_addr_bit1), .so_q(so_q), .so_oe_q(so_oe_q),
    .wiper_position_reg0_q(wiper_position_reg0_q),
    .wiper_position_reg1_q(wiper_position_reg1_q),
    .tap_sel0_q(tap_sel0_q), .tap_sel1_q(tap_sel1_q),
    .nv_busy_q(nv_busy_q), .standby_q(standby_q)
);

`default_nettype wire

// ===== sim/dpot_master.sv
// serial bus master model for the dual pot control
// assumes mclk at 4 ns; sck half period is 6 mclk (48 ns period)
`timescale 1ns/1ns
`default_nettype none

module dpot_master (
    input wire logic mclk,
    input wire logic so,
    output var logic sck,
    output var logic cs_n,
    output var logic si,
    output var logic hold_n,
    output var logic wp_n
);
    logic cpol = 1'b0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end

    task automatic half();
        repeat (6) @(negedge mclk);
    endtask

    // pause with sck low, wiggle sck and si to prove they are ignored
    task automatic pause();
        hold_n = 1'b0;
        half();
        half();
        si = ~si;
        sck = 1'b1;
        half();
        sck = 1'b0;
        si = ~si;
        half();
        hold_n = 1'b1;
        half();
    endtask

    // ------------------------------------------------
    // one frame: n bits from w[23] down, so gathered at each rise
    // ------------------------------------------------
    task automatic xfer(input logic [23:0] w, input int n, input int hld,
                        input int wpa, output logic [15:0] rd);
        rd = 16'h0000;
        sck = cpol;
        half();
        cs_n = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            si = w[23 - i];
            if (i == wpa) wp_n = 1'b0;
            if (i == wpa + 2) wp_n = 1'b1;
            if (i == hld) pause();
            half();
            sck = 1'b1;
            rd = {rd[14:0], so};
            half();
        end
        sck = cpol;
        half();
        cs_n = 1'b1;
        // released line must not keep the last bit
        si = ~si;
        half();
    endtask
endmodule

`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the dual pot serial control top
// assumes the master model drives every serial pin
`timescale 1ns/1ns
`default_nettype none
`include "dpot_defs.vh"

module testbench;
    logic mclk, nrst, dev_addr_bit0, dev_addr_bit1;
    wire logic sck, cs_n, si, hold_n, wp_n, so_q, so_oe_q, nv_busy_q, standby_q;
    wire logic [5:0] wpr0, wpr1;
    wire logic [63:0] tap0, tap1;
    wire logic so_pin = so_oe_q ? so_q : 1'bz;
    logic [15:0] rd;
    int num_errors = 0;
    int comparisons = 0;

    dpot_top #(.NVW_CYC(8)) i_dut (
        .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .dev_addr_bit0(dev_addr_bit0),
        .dev_addr_bit1(dev_addr_bit1), .so_q(so_q), .so_oe_q(so_oe_q),
        .wiper_position_reg0_q(wpr0), .wiper_position_reg1_q(wpr1),
        .tap_sel0_q(tap0), .tap_sel1_q(tap1), .nv_busy_q(nv_busy_q),
        .standby_q(standby_q)
    );
    dpot_master i_mst (
        .mclk(mclk), .so(so_pin), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n)
    );

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic frame(input logic [2:0] op, input logic pot,
                         input logic [1:0] idx, input logic [7:0] dat,
                         input int n, input int hld = 99, input int wpa = 99);
        i_mst.xfer({op, pot, idx, dev_addr_bit1, dev_addr_bit0, dat, 8'h00},
                   n, hld, wpa, rd);
    endtask

    task automatic rdchk(input logic pot, input logic [1:0] idx,
                         input logic [15:0] e, input int hld = 99);
        frame(`DPOT_OP_READ, pot, idx, 8'h00, 24, hld);
        chk("read", e, rd);
    endtask

    task automatic wait_nv();
        int k = 0;
        while (nv_busy_q !== 1'b0 && k < 40) begin
            @(negedge mclk);
            k++;
        end
        chk("nv_busy", 0, nv_busy_q);
    endtask

    task automatic results();
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        chk("wpr", 0, {wpr1, wpr0});
        chk("tap0", 64'h1, tap0);
        chk("idle", 2'h1, {so_oe_q, standby_q});
    endtask

    task automatic t_addr();
        for (int a = 0; a < 4; a++) begin
            {dev_addr_bit1, dev_addr_bit0} = a[1:0];
            i_mst.cpol = a[0];
            frame(`DPOT_OP_WR_WPR, 1'b1, 2'h0, 8'(a + 9), 16);
            chk("tap1", 64'h1 << (a + 9), tap1);
            i_mst.xfer({3'h1, 1'b1, 2'h0, a[1:0] ^ 2'h1, 8'h3f, 8'h00},
                       16, 99, 99, rd);
            chk("wpr1", a + 9, wpr1);
        end
        {dev_addr_bit1, dev_addr_bit0} = 2'h2;
        i_mst.cpol = 1'b0;
    endtask

    task automatic t_store();
        frame(`DPOT_OP_WR_WPR, 1'b0, 2'h0, 8'h2a, 16);
        frame(`DPOT_OP_STORE, 1'b0, 2'h1, 8'h00, 8);
        chk("busy", 2'h2, {nv_busy_q, standby_q});
        wait_nv();
        frame(`DPOT_OP_WR_SET, 1'b1, 2'h2, 8'h11, 16);
        wait_nv();
        frame(`DPOT_OP_WR_WPR, 1'b0, 2'h0, 8'h05, 16);
        frame(`DPOT_OP_RECALL, 1'b0, 2'h1, 8'h00, 8);
        chk("wpr0", 6'h2a, wpr0);
        rdchk(1'b0, 2'h1, 16'h2a2a);
        rdchk(1'b1, 2'h2, 16'h0c11);
    endtask

    task automatic t_wp();
        i_mst.wp_n = 1'b0;
        frame(`DPOT_OP_WR_SET, 1'b1, 2'h3, 8'h33, 16);
        wait_nv();
        frame(`DPOT_OP_WR_WPR, 1'b1, 2'h0, 8'h20, 16);
        i_mst.wp_n = 1'b1;
        rdchk(1'b1, 2'h3, 16'h2000);
        frame(`DPOT_OP_STORE, 1'b1, 2'h3, 8'h00, 8, 99, 3);
        wait_nv();
        rdchk(1'b1, 2'h3, 16'h2000);
        frame(`DPOT_OP_STORE, 1'b1, 2'h3, 8'h00, 8);
        i_mst.wp_n = 1'b0;
        wait_nv();
        i_mst.wp_n = 1'b1;
        rdchk(1'b1, 2'h3, 16'h2020);
    endtask

    task automatic t_step();
        frame(`DPOT_OP_WR_WPR, 1'b0, 2'h0, 8'h3e, 16);
        frame(`DPOT_OP_STEP, 1'b0, 2'h0, 8'he0, 11);
        chk("step_up", 6'h3f, wpr0);
        frame(`DPOT_OP_WR_WPR, 1'b0, 2'h0, 8'h01, 16);
        frame(`DPOT_OP_STEP, 1'b0, 2'h0, 8'h00, 11);
        chk("step_dn", 6'h00, wpr0);
        // opcode outside the six must leave the wiper alone
        frame(3'h6, 1'b0, 2'h0, 8'h07, 16);
        chk("bad_op", 6'h00, wpr0);
    endtask

    task automatic t_hold();
        frame(`DPOT_OP_WR_WPR, 1'b0, 2'h0, 8'h15, 16, 10);
        chk("wpr0", 6'h15, wpr0);
        rdchk(1'b0, 2'h1, 16'h152a, 13);
    endtask

    // ------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        nrst = 1'b0;
        dev_addr_bit0 = 1'b0;
        dev_addr_bit1 = 1'b1;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        repeat (10) @(negedge mclk);
        t_reset();
        t_addr();
        t_store();
        t_wp();
        t_step();
        t_hold();
        results();
    end

    // about 30 frames of 220 mclk each; allow about six times that
    initial begin
        #160000;
        num_errors++;
        results();
    end
endmodule

`default_nettype wire
